// File: test/mat_access_assertions.sv
`include "mat_regs.vh"
`timescale 1ns/100ps

// ************
// latency, arbitration and address-split checks
// ************
module mat_access_checker (
    input wire        sys_clk,
    input wire        rst_b,
    input wire [1:0]  m_req,
    input wire [1:0]  m_we,
    input wire [1:0]  m_burst,
    input wire [31:0] m_addr,
    input wire [1:0]  m_ready,
    input wire [1:0]  m_rvalid,
    input wire        ccp_unlocked,
    input wire        lock_active,
    input wire [1:0]  flash_cmd,
    input wire [15:0] z_ptr,
    input wire [1:0]  flash_op,
    input wire [7:0]  flash_page_index,
    input wire [6:0]  flash_word_in_page,
    input wire        flash_byte_sel,
    input wire        flash_page_op,
    input wire [1:0]  eeprom_cmd,
    input wire        eeprom_page_mode,
    input wire [15:0] nvm_addr,
    input wire [1:0]  eeprom_op,
    input wire [10:0] eeprom_page_index,
    input wire [4:0]  eeprom_byte_in_page,
    input wire        eeprom_page_op
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire       rd0  = m_req[0] && m_ready[0] && !m_we[0];
    wire [1:0] sec0 = m_addr[15:14];
    wire       same = m_addr[15:14] == m_addr[31:30];
    // burst continuation seen from the bus: same section, next address
    reg        prev_b;
    reg [15:0] prev_a;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_b <= 1'b0;
            prev_a <= 16'h0000;
        end else if (m_req[0] && m_ready[0]) begin
            prev_b <= m_burst[0] && !m_we[0];
            prev_a <= m_addr[15:0];
        end
    end
    wire       cont0 = prev_b && m_burst[0] && (prev_a[15:14] == sec0) &&
                       (m_addr[15:0] == prev_a + 16'h0001);

    a_io_one_cycle: assert property (rd0 && sec0 == `MAT_SECT_IO |=> m_rvalid[0])
        else $error("io read not answered next cycle");
    a_sram_two_cycles: assert property (rd0 && sec0[1] |=> !m_rvalid[0] ##1 m_rvalid[0])
        else $error("sram read latency wrong");
    a_ee_three_cycles: assert property (rd0 && sec0 == `MAT_SECT_EE && !cont0
        |=> !m_rvalid[0] [*2] ##1 m_rvalid[0]) else $error("eeprom read latency wrong");
    a_burst_pace: assert property (rd0 && sec0 == `MAT_SECT_EE && cont0
        |=> !m_rvalid[0] ##1 m_rvalid[0]) else $error("burst item not every second cycle");
    a_one_grant: assert property (m_req == 2'h3 && same |-> m_ready != 2'h3)
        else $error("two grants on one section");
    a_lock_guard: assert property ($changed(lock_active) |-> $past(ccp_unlocked))
        else $error("lock changed without unlock");
    a_flash_split: assert property ($past(rst_b) |-> flash_page_index == $past(z_ptr[15:8])
        && flash_word_in_page == $past(z_ptr[7:1])) else $error("flash split wrong");
    a_flash_op: assert property ($past(rst_b) |-> flash_op == $past(flash_cmd)
        && flash_page_op == $past(flash_cmd[1])) else $error("flash op wrong");
    a_ee_split: assert property ($past(rst_b) |-> eeprom_page_index == $past(nvm_addr[15:5])
        && eeprom_byte_in_page == $past(nvm_addr[4:0])) else $error("eeprom split wrong");
    a_ee_page_op: assert property ($past(rst_b) |-> eeprom_page_op == ($past(eeprom_page_mode)
        && $past(eeprom_cmd) != `MAT_CMD_READ)) else $error("eeprom page op wrong");

    c_sram_read: cover property (rd0 && sec0[1]);
    c_conflict: cover property (m_req == 2'h3 && same);
    c_lock_set: cover property ($rose(lock_active));
    c_burst_next: cover property (rd0 && cont0);
endmodule

bind mat_access mat_access_checker u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .m_req(m_req), .m_we(m_we), .m_burst(m_burst),
    .m_addr(m_addr), .m_ready(m_ready), .m_rvalid(m_rvalid), .ccp_unlocked(ccp_unlocked),
    .lock_active(lock_active), .flash_cmd(flash_cmd), .z_ptr(z_ptr), .flash_op(flash_op),
    .flash_page_index(flash_page_index), .flash_word_in_page(flash_word_in_page),
    .flash_byte_sel(flash_byte_sel), .flash_page_op(flash_page_op),
    .eeprom_cmd(eeprom_cmd), .eeprom_page_mode(eeprom_page_mode), .nvm_addr(nvm_addr),
    .eeprom_op(eeprom_op), .eeprom_page_index(eeprom_page_index),
    .eeprom_byte_in_page(eeprom_byte_in_page), .eeprom_page_op(eeprom_page_op)
);

// File: test/mat_access_bench.sv
`timescale 1ns/100ps

module mat_access_bench;
    reg         sys_clk, rst_b, ccp_unlocked, eeprom_page_mode;
    reg  [1:0]  flash_cmd, eeprom_cmd;
    reg  [15:0] z_ptr, nvm_addr;
    wire [1:0]  m_req, m_we, m_burst, m_ready, m_rvalid, flash_op, eeprom_op;
    wire [31:0] m_addr;
    wire [15:0] m_wdata, m_rdata;
    wire        lock_active, flash_byte_sel, flash_page_op, eeprom_page_op;
    wire [7:0]  flash_page_index;
    wire [6:0]  flash_word_in_page;
    wire [10:0] eeprom_page_index;
    wire [4:0]  eeprom_byte_in_page;
    int         num_errors = 0, compares = 0, lat, wt, lat1, wt1;
    logic [7:0] q, q1;

    mat_access u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .m_req(m_req), .m_we(m_we),
        .m_burst(m_burst), .m_addr(m_addr), .m_wdata(m_wdata), .m_ready(m_ready),
        .m_rvalid(m_rvalid), .m_rdata(m_rdata), .ccp_unlocked(ccp_unlocked),
        .lock_active(lock_active), .flash_cmd(flash_cmd), .z_ptr(z_ptr), .flash_op(flash_op),
        .flash_page_index(flash_page_index), .flash_word_in_page(flash_word_in_page),
        .flash_byte_sel(flash_byte_sel), .flash_page_op(flash_page_op),
        .eeprom_cmd(eeprom_cmd), .eeprom_page_mode(eeprom_page_mode), .nvm_addr(nvm_addr),
        .eeprom_op(eeprom_op), .eeprom_page_index(eeprom_page_index),
        .eeprom_byte_in_page(eeprom_byte_in_page), .eeprom_page_op(eeprom_page_op));
    mat_master u_m0 (.sys_clk(sys_clk), .ready(m_ready[0]), .rvalid(m_rvalid[0]),
        .rdata(m_rdata[7:0]), .req(m_req[0]), .we(m_we[0]), .burst(m_burst[0]),
        .addr(m_addr[15:0]), .wdata(m_wdata[7:0]));
    mat_master u_m1 (.sys_clk(sys_clk), .ready(m_ready[1]), .rvalid(m_rvalid[1]),
        .rdata(m_rdata[15:8]), .req(m_req[1]), .we(m_we[1]), .burst(m_burst[1]),
        .addr(m_addr[31:16]), .wdata(m_wdata[15:8]));

    // ************
    // compares and bus shorthands
    // ************
    task chk_v(input [15:0] got, input [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task chk_n(input int got, input int exp);
        compares++;
        if (got != exp) begin
            num_errors++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task wr0(input [15:0] a, input [7:0] d);
        u_m0.xfer(1'b1, 1'b0, a, d, q, lat, wt);
        chk_n(wt, 0);
    endtask
    task rd0(input [15:0] a, input [7:0] e, input int l);
        u_m0.xfer(1'b0, 1'b0, a, 8'h00, q, lat, wt);
        chk_v(q, e);
        chk_n(lat, l);
    endtask
    task set_ccp(input v);
        @(posedge sys_clk);
        ccp_unlocked <= v;
    endtask

    // ************
    // scenarios
    // ************
    task t_id;
        rd0(16'h0000, 8'h5A, 1);
        rd0(16'h0001, 8'h3C, 1);
        rd0(16'h0002, 8'h11, 1);
        rd0(16'h0003, 8'h01, 1);
        wr0(16'h0000, 8'hFF);
        rd0(16'h0000, 8'h5A, 1);
    endtask
    task t_mem;
        wr0(16'h8010, 8'hA5);
        wr0(16'hC011, 8'h5C);
        rd0(16'h8010, 8'hA5, 2);
        rd0(16'hC011, 8'h5C, 2);
        wr0(16'h4006, 8'h77);
        wr0(16'h4007, 8'h88);
        rd0(16'h4006, 8'h77, 3);
        u_m0.xfer(1'b0, 1'b1, 16'h4006, 8'h00, q, lat, wt);
        chk_n(lat, 3);
        u_m0.xfer(1'b0, 1'b1, 16'h4007, 8'h00, q, lat, wt);
        chk_v(q, 8'h88);
        chk_n(lat, 2);
    endtask
    task t_arb(input [15:0] a1, input [7:0] e1, input int w1);
        fork
            u_m0.xfer(1'b0, 1'b0, 16'h8010, 8'h00, q, lat, wt);
            u_m1.xfer(1'b0, 1'b0, a1, 8'h00, q1, lat1, wt1);
        join
        chk_v(q, 8'hA5);
        chk_v(q1, e1);
        chk_n(wt, 0);
        chk_n(wt1, w1);
    endtask
    task t_lock;
        wr0(16'h0040, 8'h11);
        set_ccp(1'b1);
        wr0(16'h0004, 8'h01);
        set_ccp(1'b0);
        chk_v(lock_active, 1'b1);
        wr0(16'h0040, 8'h22);
        rd0(16'h0040, 8'h11, 1);
        rd0(16'h0004, 8'h01, 1);
        wr0(16'h0004, 8'h00);
        @(negedge sys_clk);
        chk_v(lock_active, 1'b1);
        set_ccp(1'b1);
        wr0(16'h0004, 8'h00);
        set_ccp(1'b0);
        chk_v(lock_active, 1'b0);
        wr0(16'h005F, 8'h33);
        rd0(16'h005F, 8'h33, 1);
    endtask
    task t_nv;
        logic [2:0]  c;
        logic [15:0] z, n;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            // bit 0 of z differs between the two read passes
            z = {c, 10'h2D6, c[1], c[0], c[2]};
            n = {~c, 10'h1B9, c};
            @(posedge sys_clk);
            {flash_cmd, eeprom_cmd, eeprom_page_mode} <= {c[1:0], c[1:0], c[2]};
            {z_ptr, nvm_addr} <= {z, n};
            @(posedge sys_clk);
            @(negedge sys_clk);
            chk_v(flash_op, c[1:0]);
            chk_v(flash_page_index, z[15:8]);
            chk_v(flash_word_in_page, z[7:1]);
            chk_v(flash_byte_sel, c[1:0] == 2'h1 ? z[0] : 1'b0);
            chk_v(flash_page_op, c[1]);
            chk_v(eeprom_op, c[1:0]);
            chk_v(eeprom_page_index, n[15:5]);
            chk_v(eeprom_byte_in_page, n[4:0]);
            chk_v(eeprom_page_op, c[2] && c[1:0] != 2'h1);
        end
    endtask

    task give_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // whole run needs about a hundred cycles; the limit allows 4000
    initial begin
        #20000;
        num_errors++;
        give_verdict;
    end
    initial begin
        {rst_b, ccp_unlocked, eeprom_page_mode, flash_cmd, eeprom_cmd} = 7'h00;
        {z_ptr, nvm_addr} = 32'h0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_id;
        t_mem;
        t_arb(16'h8010, 8'hA5, 2);
        t_arb(16'hC011, 8'h5C, 0);
        t_lock;
        t_nv;
        give_verdict;
    end
endmodule

// File: test/mat_master.sv
`timescale 1ns/100ps

// ************
// one bus master: holds each request until granted or 40 cycles pass
// ************
module mat_master (
    input  wire        sys_clk,
    input  wire        ready,
    input  wire        rvalid,
    input  wire [7:0]  rdata,
    output reg         req,
    output reg         we,
    output reg         burst,
    output reg  [15:0] addr,
    output reg  [7:0]  wdata
);
    initial {req, we, burst, addr, wdata} = 27'h0;

    task xfer(input w, input b, input [15:0] a, input [7:0] d,
              output [7:0] q, output int lat, output int wt);
        wt = 0;
        lat = 0;
        q = 8'h00;
        @(posedge sys_clk);
        {req, we, burst, addr, wdata} <= {1'b1, w, b, a, d};
        @(negedge sys_clk);
        while (!ready && wt < 40) begin
            wt++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        req <= 1'b0;
        // released lines flip so stale values cannot pass
        addr <= ~a;
        wdata <= ~d;
        if (!w) begin
            do begin
                @(negedge sys_clk);
                lat++;
            end while (!rvalid && lat < 8);
            q = rdata;
        end
    endtask
endmodule

// File: verilog/mat_access.v
`include "mat_regs.vh"
`timescale 1ns/100ps

// Summary of operation
// - data memory is four sections; masters on different sections proceed together.
// - i/o register reads and writes finish in one cycle.
// - sram write takes one cycle; sram read returns data after two.
// - eeprom buffer load takes one cycle; eeprom read takes three.
// - eeprom burst reads deliver a new item every second cycle.
// - three read-only id bytes and a read-only revision register.
// - while locked, writes to clock, event and waveform registers are dropped.
// - lock register accepts writes only after the protection unlock.
// - flash pages hold 16-bit words, eeprom pages hold bytes.
// - flash erase and program act on whole pages; reads return bytes.
// - flash address from z pointer: high bits page, low bits word.
// - 128 words per page; word index from z[7:1], page above.
// - eeprom allows page or byte erase and write; reads return bytes.
// - eeprom address register splits into page and byte in page.
module mat_access #(
    parameter [7:0] ID_BYTE0 = 8'h5A,  // arbitrary
    parameter [7:0] ID_BYTE1 = 8'h3C,  // arbitrary
    parameter [7:0] ID_BYTE2 = 8'h11,  // arbitrary
    parameter [7:0] REVISION = 8'h01   // arbitrary
) (
    input  wire                                 sys_clk,
    input  wire                                 rst_b,
    input  wire [`MAT_NMAST-1:0]                m_req,
    input  wire [`MAT_NMAST-1:0]                m_we,
    input  wire [`MAT_NMAST-1:0]                m_burst,
    input  wire [`MAT_NMAST*`MAT_AW-1:0]        m_addr,
    input  wire [`MAT_NMAST*`MAT_DW-1:0]        m_wdata,
    output wire [`MAT_NMAST-1:0]                m_ready,
    output wire [`MAT_NMAST-1:0]                m_rvalid,
    output wire [`MAT_NMAST*`MAT_DW-1:0]        m_rdata,
    input  wire                                 ccp_unlocked,
    output reg                                  lock_active,
    input  wire [1:0]                           flash_cmd,
    input  wire [`MAT_AW-1:0]                   z_ptr,
    output reg  [1:0]                           flash_op,
    output reg  [`MAT_FLASH_PAGE_INDEX_HI-`MAT_FLASH_PAGE_INDEX_LO:0] flash_page_index,
    output reg  [`MAT_FLASH_WORD_IN_PAGE_HI-`MAT_FLASH_WORD_IN_PAGE_LO:0] flash_word_in_page,
    output reg                                  flash_byte_sel,
    output reg                                  flash_page_op,
    input  wire [1:0]                           eeprom_cmd,
    input  wire                                 eeprom_page_mode,
    input  wire [`MAT_AW-1:0]                   nvm_addr,
    output reg  [1:0]                           eeprom_op,
    output reg  [`MAT_AW-1-`MAT_EPAGE_LO:0]     eeprom_page_index,
    output reg  [`MAT_EBYTE_HI:0]               eeprom_byte_in_page,
    output reg                                  eeprom_page_op
);

    // ***************************************************************
    // request decode per master
    // ***************************************************************
    wire [1:0]          sect      [0:`MAT_NMAST-1];
    wire [`MAT_AW-1:0]  addr      [0:`MAT_NMAST-1];
    wire [`MAT_DW-1:0]  wdata     [0:`MAT_NMAST-1];
    reg  [1:0]          cnt       [0:`MAT_NMAST-1];
    reg  [1:0]          cur_sect  [0:`MAT_NMAST-1];
    reg  [`MAT_AW-1:0]  last_addr [0:`MAT_NMAST-1];
    reg                 last_burst[0:`MAT_NMAST-1];
    reg                 io_ovr    [0:`MAT_NMAST-1];
    reg  [`MAT_DW-1:0]  io_val    [0:`MAT_NMAST-1];
    wire [`MAT_NMAST-1:0] want;
    wire [3:0]          sect_busy;
    wire [`MAT_NMAST-1:0] take;
    wire [`MAT_DW-1:0]  sect_rdata [0:3];

    genvar gm;
    generate
        for (gm = 0; gm < `MAT_NMAST; gm = gm + 1) begin : g_dec
            assign sect[gm]  = m_addr[gm*`MAT_AW+`MAT_SECT_HI -: 2];
            assign addr[gm]  = m_addr[gm*`MAT_AW +: `MAT_AW];
            assign wdata[gm] = m_wdata[gm*`MAT_DW +: `MAT_DW];
            // a master may issue again in the cycle its data returns
            assign want[gm]  = m_req[gm] && (cnt[gm] <= 2'h1);
        end
    endgenerate

    // ***************************************************************
    // section arbitration
    // ***************************************************************
    // a section stays busy until its read data has been handed back
    genvar gs;
    generate
        for (gs = 0; gs < 4; gs = gs + 1) begin : g_busy
            assign sect_busy[gs] =
                ((cnt[0] > 2'h1) && (cur_sect[0] == gs)) ||
                ((cnt[1] > 2'h1) && (cur_sect[1] == gs));
        end
    endgenerate

    // fixed priority: master 0 wins a clash, master 1 waits
    assign take[0] = want[0] && !sect_busy[sect[0]];
    assign take[1] = want[1] && !sect_busy[sect[1]] &&
                     !(take[0] && (sect[0] == sect[1]));
    assign m_ready = take;

    // ***************************************************************
    // section memories
    // ***************************************************************
    // i/o protection: lock register and locked window
    wire [`MAT_NMAST-1:0] io_prot;
    wire [`MAT_NMAST-1:0] io_lockreg;
    wire [`MAT_NMAST-1:0] io_wr_ok;
    generate
        for (gm = 0; gm < `MAT_NMAST; gm = gm + 1) begin : g_prot
            assign io_prot[gm]    = (addr[gm][7:0] >= `MAT_IO_PROT_LO) &&
                                    (addr[gm][7:0] <= `MAT_IO_PROT_HI);
            assign io_lockreg[gm] = (addr[gm][7:0] == `MAT_IO_LOCK);
            assign io_wr_ok[gm]   = !(io_prot[gm] && lock_active);
        end
    endgenerate

    generate
        for (gs = 0; gs < 4; gs = gs + 1) begin : g_sect
            wire                   sel0 = take[0] && (sect[0] == gs);
            wire                   sel1 = take[1] && (sect[1] == gs);
            wire                   pick = sel0 ? 1'b0 : 1'b1;
            wire                   s_we = m_we[pick];
            wire                   s_ok = (gs != `MAT_SECT_IO) || io_wr_ok[pick];
            wire                   s_en = (sel0 || sel1) && (!s_we || s_ok);
            mat_mem #(
                .AW (`MAT_MEM_AW),
                .DW (`MAT_DW)
            ) u_mem (
                .sys_clk (sys_clk),
                .en      (s_en),
                .we      (s_we),
                .addr    (addr[pick][`MAT_MEM_AW-1:0]),
                .wdata   (wdata[pick]),
                .rdata   (sect_rdata[gs])
            );
        end
    endgenerate

    // ***************************************************************
    // per-master latency tracking and read return
    // ***************************************************************
    generate
        for (gm = 0; gm < `MAT_NMAST; gm = gm + 1) begin : g_trk
            reg [1:0] next_lat;
            wire      cont = last_burst[gm] && m_burst[gm] &&
                             (cur_sect[gm] == sect[gm]) &&
                             (addr[gm] == last_addr[gm] + 16'h0001);
            always @* begin
                case (sect[gm])
                    `MAT_SECT_IO: next_lat = `MAT_LAT_IO;
                    `MAT_SECT_EE: next_lat = cont ? `MAT_LAT_BURST
                                                  : `MAT_LAT_EE;
                    default:      next_lat = `MAT_LAT_SRAM;
                endcase
            end
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt[gm]        <= 2'h0;
                    cur_sect[gm]   <= 2'h0;
                    last_addr[gm]  <= 16'h0000;
                    last_burst[gm] <= 1'b0;
                    io_ovr[gm]     <= 1'b0;
                    io_val[gm]     <= 8'h00;
                end else if (take[gm]) begin
                    // writes finish in their own cycle: nothing in flight
                    cnt[gm]        <= m_we[gm] ? 2'h0 : next_lat;
                    cur_sect[gm]   <= sect[gm];
                    last_addr[gm]  <= addr[gm];
                    last_burst[gm] <= m_burst[gm] && !m_we[gm];
                    io_ovr[gm]     <= 1'b1;
                    case (addr[gm][7:0])
                        `MAT_IO_ID0:  io_val[gm] <= ID_BYTE0;
                        `MAT_IO_ID1:  io_val[gm] <= ID_BYTE1;
                        `MAT_IO_ID2:  io_val[gm] <= ID_BYTE2;
                        `MAT_IO_REV:  io_val[gm] <= REVISION;
                        `MAT_IO_LOCK: io_val[gm] <= {7'h00, lock_active};
                        default:      io_ovr[gm] <= 1'b0;
                    endcase
                end else if (cnt[gm] != 2'h0) begin
                    cnt[gm] <= cnt[gm] - 2'h1;
                end
            end
            assign m_rvalid[gm] = (cnt[gm] == 2'h1);
            assign m_rdata[gm*`MAT_DW +: `MAT_DW] =
                ((cur_sect[gm] == `MAT_SECT_IO) && io_ovr[gm]) ? io_val[gm]
                                                              : sect_rdata[cur_sect[gm]];
        end
    endgenerate

    // ***************************************************************
    // protection lock
    // ***************************************************************
    // id and revision live in the lock-free decode, never in the array,
    // so a write there lands in unread storage and is harmless
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_active <= `MAT_LOCK_RST;
        end else if (take[0] && m_we[0] && (sect[0] == `MAT_SECT_IO) &&
                     io_lockreg[0] && ccp_unlocked) begin
            lock_active <= wdata[0][0];
        end else if (take[1] && m_we[1] && (sect[1] == `MAT_SECT_IO) &&
                     io_lockreg[1] && ccp_unlocked) begin
            lock_active <= wdata[1][0];
        end
    end

    // ***************************************************************
    // flash address split
    // ***************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_op           <= `MAT_CMD_NONE;
            flash_page_index   <= 8'h00;
            flash_word_in_page <= 7'h00;
            flash_byte_sel     <= 1'b0;
            flash_page_op      <= 1'b0;
        end else begin
            flash_op         <= flash_cmd;
            flash_page_index <= z_ptr[`MAT_FLASH_PAGE_INDEX_HI:`MAT_FLASH_PAGE_INDEX_LO];
            // erase and program always cover the page, word index unused
            flash_page_op    <= (flash_cmd == `MAT_CMD_ERASE) ||
                                (flash_cmd == `MAT_CMD_WRITE);
            if (flash_cmd == `MAT_CMD_READ) begin
                flash_word_in_page <= z_ptr[`MAT_FLASH_WORD_IN_PAGE_HI:`MAT_FLASH_WORD_IN_PAGE_LO];
                flash_byte_sel     <= z_ptr[0];
            end else begin
                flash_word_in_page <= z_ptr[`MAT_FLASH_WORD_IN_PAGE_HI:`MAT_FLASH_WORD_IN_PAGE_LO];
                flash_byte_sel     <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // eeprom address split
    // ***************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            eeprom_op           <= `MAT_CMD_NONE;
            eeprom_page_index   <= 11'h000;
            eeprom_byte_in_page <= 5'h00;
            eeprom_page_op      <= 1'b0;
        end else begin
            eeprom_op           <= eeprom_cmd;
            eeprom_page_index   <= nvm_addr[`MAT_AW-1:`MAT_EPAGE_LO];
            eeprom_byte_in_page <= nvm_addr[`MAT_EBYTE_HI:0];
            // reads are always single byte; page mode applies to every command except read
            eeprom_page_op      <= eeprom_page_mode &&
                                   (eeprom_cmd != `MAT_CMD_READ);
        end
    end

endmodule

// File: verilog/mat_mem.v
`timescale 1ns/100ps

// ***************************************************************
// one data-memory section, registered read port
// ***************************************************************
module mat_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          sys_clk,
    input  wire          en,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array; read data holds until the next read
    always @(posedge sys_clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
        if (en && !we) begin
            rdata <= mem[addr];
        end
    end

endmodule

// File: verilog/mat_regs.vh
`ifndef MAT_REGS_VH
`define MAT_REGS_VH

// ***************************************************************
// bus shape
// ***************************************************************
`define MAT_NMAST         2
`define MAT_AW            16
`define MAT_DW            8
`define MAT_SECT_HI       15
`define MAT_SECT_LO       14
`define MAT_MEM_AW        8

// ***************************************************************
// section codes
// ***************************************************************
`define MAT_SECT_IO       2'h0
`define MAT_SECT_EE       2'h1
`define MAT_SECT_SRAM0    2'h2
`define MAT_SECT_SRAM1    2'h3

// ***************************************************************
// access latencies in cpu cycles
// ***************************************************************
`define MAT_LAT_IO        2'h1
`define MAT_LAT_SRAM      2'h2
`define MAT_LAT_EE        2'h3
`define MAT_LAT_BURST     2'h2

// ***************************************************************
// i/o register offsets
// ***************************************************************
`define MAT_IO_ID0        8'h00
`define MAT_IO_ID1        8'h01
`define MAT_IO_ID2        8'h02
`define MAT_IO_REV        8'h03
`define MAT_IO_LOCK       8'h04
`define MAT_IO_PROT_LO    8'h40
`define MAT_IO_PROT_HI    8'h5F
`define MAT_LOCK_RST      1'h0

// ***************************************************************
// nonvolatile addressing
// ***************************************************************
`define MAT_FLASH_WORD_IN_PAGE_HI      7
`define MAT_FLASH_WORD_IN_PAGE_LO      1
`define MAT_FLASH_PAGE_INDEX_HI      15
`define MAT_FLASH_PAGE_INDEX_LO      8
`define MAT_EBYTE_HI      4
`define MAT_EPAGE_LO      5
`define MAT_CMD_NONE      2'h0
`define MAT_CMD_READ      2'h1
`define MAT_CMD_ERASE     2'h2
`define MAT_CMD_WRITE     2'h3

`endif
